// File: hdl/cmd_decoder.sv
/*
 memory map decoder: flash bank select, data ram map, register banks, bit space,
 stack pointer, paged sfr access.
 assumes the core presents one access per cycle and drives sfr writes with sfr_we.
*/
// What this block does
// - constant bank field picks flash bank for constant reads/writes at upper half.
// - scratchpad accesses ignore the constant bank field.
// - fetch bank field picks flash bank for upper-half instruction fetches.
// - fetch bank field changes only when writer executes from common bank 0.
// - lower program half always decodes to bank 0.
// - bank select register at 0xb1, reachable on every page; bits 7-6, 3-2 reserved.
// - 256 bytes data ram; lower 128 bytes direct or indirect.
// - above 0x7f direct reaches sfrs, indirect reaches upper ram.
// - 0x00-0x1f are four register banks chosen by status word bits 3, 4.
// - indirect address comes from r0 or of active bank.
// - bytes 0x20-0x2f form bit addresses 0x00-0x7f.
// - bit or byte access chosen by operand type, not address.
// - push writes at pointer plus one, then pointer increments.
// - reset loads stack pointer at 0x81 with 0x07.
// - 32-bit stack record shifts one bit per push, two per call.
// - stack record flags overflow and underflow to debug logic.
// - sfrs at addresses ending 0 or 8 are bit addressable.
// - up to 256 sfr pages chosen by page select register.
`timescale 1ns/10ps
module cmd_decoder (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [15:0]       fetch_addr,
    input  wire logic              fetch_req,
    input  wire logic [15:0]       const_addr,
    input  wire logic              const_req,
    input  wire logic              const_scratch,
    input  wire logic [15:0]       exec_pc,
    input  wire cmd_pkg::cmd_mode_e data_mode,
    input  wire logic [7:0]        data_addr,
    input  wire logic [7:0]        indirect_ptr,
    input  wire logic              indirect_sel,
    input  wire logic              sfr_we,
    input  wire logic              sfr_re,
    input  wire logic [7:0]        sfr_wdata,
    input  wire cmd_pkg::cmd_stk_e stack_op,
    output logic [16:0]            fetch_flash_addr,
    output logic [16:0]            const_flash_addr,
    output logic [7:0]             ram_addr,
    output logic                   ram_sel,
    output logic                   ram_bit_sel,
    output logic [2:0]             bit_pos,
    output logic [7:0]             sfr_addr,
    output logic [7:0]             sfr_page,
    output logic                   sfr_sel,
    output logic                   sfr_bit_ok,
    output logic [7:0]             ptr_reg_addr,
    output logic [7:0]             sfr_rdata,
    output logic                   sfr_rvalid,
    output logic [7:0]             stack_pointer,
    output logic [7:0]             push_addr,
    output logic                   rec_overflow,
    output logic                   rec_underflow
);
    import cmd_pkg::*;

    logic [7:0] program_bank_select_r;
    logic [7:0] peripheral_page_select_r;
    logic [7:0] program_status_word_r;
    logic [7:0] stack_pointer_r;
    logic [1:0] constant_bank_field;
    logic [1:0] fetch_bank_field;
    logic [1:0] reg_bank;
    logic       reg_bank_sel_lo;
    logic       reg_bank_sel_hi;
    logic       in_bank0;
    cmd_stk_if  stk ();

    assign constant_bank_field = program_bank_select_r[CMD_CB_LSB +: 2];
    assign fetch_bank_field    = program_bank_select_r[CMD_FB_LSB +: 2];
    assign reg_bank_sel_lo     = program_status_word_r[CMD_RS_LSB];
    assign reg_bank_sel_hi     = program_status_word_r[CMD_RS_LSB + 1];
    assign reg_bank            = {reg_bank_sel_hi, reg_bank_sel_lo};
    assign in_bank0            = ~exec_pc[15];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            program_bank_select_r <= CMD_PBS_RESET;
        end else if (sfr_we && data_mode == CMD_DIRECT && data_addr == CMD_PBS_ADDR) begin
            program_bank_select_r[CMD_CB_LSB +: 2] <= sfr_wdata[CMD_CB_LSB +: 2];
            // fetch bank from bank 0 only
            if (in_bank0) begin
                program_bank_select_r[CMD_FB_LSB +: 2] <= sfr_wdata[CMD_FB_LSB +: 2];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            peripheral_page_select_r <= CMD_PAGE_RESET;
        end else if (sfr_we && data_mode == CMD_DIRECT && data_addr == CMD_PAGE_ADDR) begin
            peripheral_page_select_r <= sfr_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            program_status_word_r <= 8'h00;
        end else if (sfr_we && data_mode == CMD_DIRECT && data_addr == CMD_PSW_ADDR) begin
            program_status_word_r <= sfr_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stack_pointer_r <= CMD_SP_RESET;
        end else if (sfr_we && data_mode == CMD_DIRECT && data_addr == CMD_SP_ADDR) begin
            stack_pointer_r <= sfr_wdata;
        end else begin
            case (stack_op)
                CMD_SP_PUSH: stack_pointer_r <= stack_pointer_r + 8'h01;
                CMD_SP_CALL: stack_pointer_r <= stack_pointer_r + 8'h02;
                CMD_SP_POP:  stack_pointer_r <= stack_pointer_r - 8'h01;
                CMD_SP_RET:  stack_pointer_r <= stack_pointer_r - 8'h02;
                default:     stack_pointer_r <= stack_pointer_r;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetch_flash_addr <= 17'h0;
        end else if (fetch_req) begin
            fetch_flash_addr <= fetch_addr[15] ? {fetch_bank_field, fetch_addr[14:0]}
                                               : {2'b00, fetch_addr[14:0]};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            const_flash_addr <= 17'h0;
        end else if (const_req) begin
            if (const_scratch || !const_addr[15]) begin
                const_flash_addr <= {2'b00, const_addr[14:0]};
            end else begin
                const_flash_addr <= {constant_bank_field, const_addr[14:0]};
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ram_addr    <= 8'h00;
            ram_sel     <= 1'b0;
            ram_bit_sel <= 1'b0;
            bit_pos     <= 3'h0;
            sfr_addr    <= 8'h00;
            sfr_sel     <= 1'b0;
            sfr_bit_ok  <= 1'b0;
        end else begin
            ram_sel     <= 1'b0;
            ram_bit_sel <= 1'b0;
            sfr_sel     <= 1'b0;
            sfr_bit_ok  <= 1'b0;
            if (data_mode == CMD_INDIRECT) begin
                ram_addr <= indirect_ptr;
                ram_sel  <= 1'b1;
            end else if (data_mode == CMD_DIRECT && data_addr < CMD_SFR_BASE) begin
                ram_addr <= data_addr;
                ram_sel  <= 1'b1;
            end else if (data_mode == CMD_DIRECT) begin
                sfr_addr <= data_addr;
                sfr_sel  <= 1'b1;
            end else if (data_mode == CMD_BIT && !data_addr[7]) begin
                ram_addr    <= CMD_BIT_BYTE_BASE + {4'h0, data_addr[6:3]};
                ram_sel     <= 1'b1;
                ram_bit_sel <= 1'b1;
                bit_pos     <= data_addr[2:0];
            end else if (data_mode == CMD_BIT) begin
                sfr_addr   <= {data_addr[7:3], 3'b000};
                sfr_sel    <= 1'b1;
                sfr_bit_ok <= 1'b1;
                bit_pos    <= data_addr[2:0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ptr_reg_addr <= 8'h00;
        end else begin
            ptr_reg_addr <= {3'b000, reg_bank, 2'b00, indirect_sel};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sfr_rdata  <= 8'h00;
            sfr_rvalid <= 1'b0;
        end else begin
            sfr_rvalid <= 1'b0;
            sfr_rdata  <= 8'h00;
            if (sfr_re && data_mode == CMD_DIRECT) begin
                if (data_addr == CMD_PBS_ADDR) begin
                    sfr_rdata  <= program_bank_select_r & CMD_PBS_MASK;
                    sfr_rvalid <= 1'b1;
                end else if (data_addr == CMD_SP_ADDR) begin
                    sfr_rdata  <= stack_pointer_r;
                    sfr_rvalid <= 1'b1;
                end else if (data_addr == CMD_PAGE_ADDR) begin
                    sfr_rdata  <= peripheral_page_select_r;
                    sfr_rvalid <= 1'b1;
                end else if (data_addr == CMD_PSW_ADDR) begin
                    sfr_rdata  <= program_status_word_r;
                    sfr_rvalid <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stack_pointer <= CMD_SP_RESET;
            push_addr     <= CMD_SP_RESET + 8'h01;
            sfr_page      <= CMD_PAGE_RESET;
        end else begin
            stack_pointer <= stack_pointer_r;
            push_addr     <= stack_pointer_r + 8'h01;
            sfr_page      <= peripheral_page_select_r;
        end
    end

    assign stk.op = stack_op;
    cmd_stack_record u_rec (
        .clk (clk),
        .rst (rst),
        .stk (stk)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rec_overflow  <= 1'b0;
            rec_underflow <= 1'b0;
        end else begin
            rec_overflow  <= stk.ovf;
            rec_underflow <= stk.unf;
        end
    end

    fetch_lock_a: assert property (@(posedge clk) disable iff (rst)
        (exec_pc[15] && !(sfr_we && data_mode == CMD_DIRECT && data_addr == CMD_PBS_ADDR
         && in_bank0)) |=> $stable(fetch_bank_field))
        else $error("fetch bank changed from upper bank");
    low_half_a: assert property (@(posedge clk) disable iff (rst)
        (fetch_req && !fetch_addr[15]) |=> fetch_flash_addr[16:15] == 2'b00)
        else $error("lower half not bank 0");
    upper_fetch_a: assert property (@(posedge clk) disable iff (rst)
        (fetch_req && fetch_addr[15]) |=> fetch_flash_addr[16:15] == $past(fetch_bank_field))
        else $error("upper fetch bank wrong");
    scratch_ign_a: assert property (@(posedge clk) disable iff (rst)
        (const_req && const_scratch) |=> const_flash_addr[16:15] == 2'b00)
        else $error("scratchpad used constant bank");
    direct_sfr_a: assert property (@(posedge clk) disable iff (rst)
        (data_mode == CMD_DIRECT && data_addr[7]) |=> sfr_sel && !ram_sel)
        else $error("direct high address missed sfr");
    indir_ram_a: assert property (@(posedge clk) disable iff (rst)
        (data_mode == CMD_INDIRECT) |=> ram_sel && ram_addr == $past(indirect_ptr))
        else $error("indirect access missed ram");
    bit_map_a: assert property (@(posedge clk) disable iff (rst)
        (data_mode == CMD_BIT && !data_addr[7]) |=>
        ram_addr == 8'h20 + {4'h0, $past(data_addr[6:3])} && bit_pos == $past(data_addr[2:0]))
        else $error("bit address mapping wrong");
    push_step_a: assert property (@(posedge clk) disable iff (rst)
        (stack_op == CMD_SP_PUSH && !sfr_we) |=> ##1 stack_pointer == $past(stack_pointer_r, 2) + 8'h01)
        else $error("push did not increment pointer");
    rsv_zero_a: assert property (@(posedge clk) disable iff (rst)
        sfr_rvalid && $past(data_addr) == CMD_PBS_ADDR |-> (sfr_rdata & 8'hcc) == 8'h00)
        else $error("reserved bank bits read nonzero");

    // flash bank checks
    const_hi_a: assert property (@(posedge clk) disable iff (rst)
        (const_req && !const_scratch && const_addr[15]) |=>
        const_flash_addr[16:15] == $past(constant_bank_field))
        else $error("upper constant bank wrong");
    const_lo_a: assert property (@(posedge clk) disable iff (rst)
        (const_req && !const_addr[15]) |=> const_flash_addr[16:15] == 2'b00)
        else $error("lower constant half not bank 0");
    bank_write_a: assert property (@(posedge clk) disable iff (rst)
        (sfr_we && data_mode == CMD_DIRECT && data_addr == CMD_PBS_ADDR) |=>
        constant_bank_field == $past(sfr_wdata[CMD_CB_LSB +: 2]))
        else $error("bank select write lost");
    rsv_hold_a: assert property (@(posedge clk) disable iff (rst)
        (program_bank_select_r & ~CMD_PBS_MASK) == 8'h00)
        else $error("reserved bank bits stored");

    // data space checks
    direct_ram_a: assert property (@(posedge clk) disable iff (rst)
        (data_mode == CMD_DIRECT && !data_addr[7]) |=>
        ram_sel && !sfr_sel && ram_addr == $past(data_addr))
        else $error("direct low address missed ram");
    byte_only_a: assert property (@(posedge clk) disable iff (rst)
        (data_mode == CMD_DIRECT) |=> !ram_bit_sel && !sfr_bit_ok)
        else $error("byte access marked as bit");
    sfr_bit_a: assert property (@(posedge clk) disable iff (rst)
        (data_mode == CMD_BIT && data_addr[7]) |=> sfr_bit_ok && sfr_addr[2:0] == 3'b000)
        else $error("sfr bit access not on 0 or 8");
    ptr_bank_a: assert property (@(posedge clk) disable iff (rst)
        (data_mode == CMD_INDIRECT) |=>
        ptr_reg_addr[7:3] == {3'b000, $past(reg_bank)} &&
        ptr_reg_addr[2:0] == {2'b00, $past(indirect_sel)})
        else $error("pointer register outside active bank");

    // register checks
    sp_reset_a: assert property (@(posedge clk)
        $fell(rst) |-> stack_pointer_r == CMD_SP_RESET && push_addr == CMD_SP_RESET + 8'h01)
        else $error("stack pointer reset value wrong");
    page_mirror_a: assert property (@(posedge clk) disable iff (rst)
        (sfr_we && data_mode == CMD_DIRECT && data_addr == CMD_PAGE_ADDR) |=> ##1
        sfr_page == $past(sfr_wdata, 2))
        else $error("page select not reflected");
    rec_flag_a: assert property (@(posedge clk) disable iff (rst)
        stk.ovf |=> rec_overflow)
        else $error("overflow not passed to debug");

    // scenario covers
    cover property (@(posedge clk) disable iff (rst) const_req && const_scratch);
    cover property (@(posedge clk) disable iff (rst) fetch_req && fetch_addr[15] && fetch_bank_field == 2'b11);
    cover property (@(posedge clk) disable iff (rst) data_mode == CMD_BIT && data_addr[7]);
    cover property (@(posedge clk) disable iff (rst) stack_op == CMD_SP_CALL);
endmodule

// File: hdl/cmd_pkg.sv
/*
 memory map decoder package: register offsets, field positions, reset values, map bounds.
 assumes nothing beyond a systemverilog compiler.
*/
package cmd_pkg;
    localparam logic [7:0]  CMD_SP_ADDR       = 8'h81;
    localparam logic [7:0]  CMD_SP_RESET      = 8'h07;
    localparam logic [7:0]  CMD_PBS_ADDR      = 8'hb1;
    localparam logic [7:0]  CMD_PAGE_ADDR     = 8'h84;
    localparam logic [7:0]  CMD_PSW_ADDR      = 8'hd0;
    localparam logic [7:0]  CMD_PBS_RESET     = 8'h11;
    localparam logic [7:0]  CMD_PBS_MASK      = 8'h33;
    localparam int          CMD_CB_LSB        = 4;
    localparam int          CMD_FB_LSB        = 0;
    localparam int          CMD_RS_LSB        = 3;
    localparam logic [7:0]  CMD_SFR_BASE      = 8'h80;
    localparam logic [7:0]  CMD_BIT_BYTE_BASE = 8'h20;
    localparam logic [7:0]  CMD_PAGE_RESET    = 8'h00;
    localparam int          CMD_REC_W         = 32;
    localparam logic [5:0]  CMD_REC_FULL      = 6'h20;
    typedef enum logic [1:0] {CMD_NONE, CMD_DIRECT, CMD_INDIRECT, CMD_BIT} cmd_mode_e;
    typedef enum logic [2:0] {
        CMD_SP_HOLD, CMD_SP_PUSH, CMD_SP_POP, CMD_SP_CALL, CMD_SP_RET
    } cmd_stk_e;
endpackage

// File: hdl/cmd_stk_if.sv
/*
 interface carrying stack events between the decoder and the stack record.
 assumes one clock domain.
*/
`timescale 1ns/10ps
interface cmd_stk_if;
    import cmd_pkg::*;
    cmd_stk_e op;
    logic     ovf;
    logic     unf;
    modport src (output op, input ovf, unf);
    modport rec (input op, output ovf, unf);
endinterface

// File: hdl/cmd_stack_record.sv
/*
 debug stack record: 32-bit shift register with depth count and overflow/underflow pulses.
 assumes stack events arrive one per cycle at most.
*/
`timescale 1ns/10ps
module cmd_stack_record (
    input  wire logic clk,
    input  wire logic rst,
    cmd_stk_if.rec    stk
);
    import cmd_pkg::*;
    logic [CMD_REC_W-1:0] rec_r;
    logic [5:0]           depth_r;
    logic                 ovf_r;
    logic                 unf_r;
    logic [5:0]           need;
    logic [5:0]           give;

    always_comb begin
        need = 6'h0;
        give = 6'h0;
        case (stk.op)
            CMD_SP_PUSH: need = 6'h1;
            CMD_SP_CALL: need = 6'h2;
            CMD_SP_POP:  give = 6'h1;
            CMD_SP_RET:  give = 6'h2;
            default:     need = 6'h0;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rec_r   <= '0;
            depth_r <= 6'h0;
        end else if (need != 6'h0) begin
            rec_r   <= (need == 6'h2) ? {rec_r[CMD_REC_W-3:0], 2'b11} : {rec_r[CMD_REC_W-2:0], 1'b0};
            depth_r <= (depth_r + need > CMD_REC_FULL) ? CMD_REC_FULL : depth_r + need;
        end else if (give != 6'h0) begin
            rec_r   <= (give == 6'h2) ? {2'b00, rec_r[CMD_REC_W-1:2]} : {1'b0, rec_r[CMD_REC_W-1:1]};
            depth_r <= (depth_r < give) ? 6'h0 : depth_r - give;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovf_r <= 1'b0;
            unf_r <= 1'b0;
        end else begin
            ovf_r <= (need != 6'h0) && (depth_r + need > CMD_REC_FULL);
            unf_r <= (give != 6'h0) && (depth_r < give);
        end
    end
    assign stk.ovf = ovf_r;
    assign stk.unf = unf_r;

    ovf_pulse_a: assert property (@(posedge clk) disable iff (rst)
        (stk.op == CMD_SP_CALL && depth_r == 6'h1f) |=> stk.ovf)
        else $error("overflow not flagged");
    unf_pulse_a: assert property (@(posedge clk) disable iff (rst)
        (stk.op == CMD_SP_POP && depth_r == 6'h0) |=> stk.unf)
        else $error("underflow not flagged");
    rec_depth_a: assert property (@(posedge clk) disable iff (rst)
        (stk.op == CMD_SP_CALL && depth_r < 6'h1e) |=> depth_r == $past(depth_r) + 6'h2)
        else $error("call did not add two record bits");
    cover property (@(posedge clk) disable iff (rst) stk.ovf);
endmodule

// File: test/cmd_core_model.sv
/*
 cpu core model: launches fetch, constant, data, sfr and stack requests, at most one of each per cycle.
 assumes the decoder samples on the rising edge; requests change on the falling edge.
*/
`timescale 1ns/10ps
module cmd_core_model (
    input  wire logic             clk,
    output logic [15:0]           fetch_addr,
    output logic                  fetch_req,
    output logic [15:0]           const_addr,
    output logic                  const_req,
    output logic                  const_scratch,
    output logic [15:0]           exec_pc,
    output cmd_pkg::cmd_mode_e    data_mode,
    output logic [7:0]            data_addr,
    output logic [7:0]            indirect_ptr,
    output logic                  indirect_sel,
    output logic                  sfr_we,
    output logic                  sfr_re,
    output logic [7:0]            sfr_wdata,
    output cmd_pkg::cmd_stk_e     stack_op
);
    import cmd_pkg::*;
    logic [15:0] fa_nxt, ca_nxt, pc_nxt;
    logic [7:0]  da_nxt, ip_nxt, wd_nxt;
    logic        fr_nxt, cr_nxt, cs_nxt, is_nxt, we_nxt, re_nxt;
    cmd_mode_e   md_nxt;
    cmd_stk_e    op_nxt;
    task automatic clear();
        {fr_nxt, cr_nxt, cs_nxt, is_nxt, we_nxt, re_nxt} = '0;
        {fa_nxt, ca_nxt, pc_nxt, da_nxt, ip_nxt, wd_nxt} = '0;
        md_nxt = CMD_NONE;
        op_nxt = CMD_SP_HOLD;
    endtask
    initial begin
        {fetch_addr, const_addr, exec_pc, data_addr, indirect_ptr, sfr_wdata} = '0;
        {fetch_req, const_req, const_scratch, indirect_sel, sfr_we, sfr_re} = '0;
        data_mode = CMD_NONE;
        stack_op = CMD_SP_HOLD;
        clear();
    end
    // idle address lines invert so a stale value never looks like a live request
    task automatic issue();
        @(negedge clk);
        fetch_addr    = fr_nxt ? fa_nxt : ~fetch_addr;
        fetch_req     = fr_nxt;
        const_addr    = cr_nxt ? ca_nxt : ~const_addr;
        const_req     = cr_nxt;
        const_scratch = cs_nxt;
        exec_pc       = pc_nxt;
        data_mode     = md_nxt;
        data_addr     = (md_nxt != CMD_NONE) ? da_nxt : ~data_addr;
        indirect_ptr  = ip_nxt;
        indirect_sel  = is_nxt;
        sfr_we        = we_nxt;
        sfr_re        = re_nxt;
        sfr_wdata     = we_nxt ? wd_nxt : ~sfr_wdata;
        stack_op      = op_nxt;
        clear();
    endtask
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v, input logic [15:0] pc);
        md_nxt = CMD_DIRECT;
        da_nxt = a;
        wd_nxt = v;
        we_nxt = 1'b1;
        pc_nxt = pc;
        issue();
    endtask
    task automatic sfr_rd(input logic [7:0] a);
        md_nxt = CMD_DIRECT;
        da_nxt = a;
        re_nxt = 1'b1;
        issue();
    endtask
    task automatic paged(input logic [7:0] p, input logic [7:0] a);
        sfr_wr(CMD_PAGE_ADDR, p, 16'h0000);
        md_nxt = CMD_DIRECT;
        da_nxt = a;
        issue();
    endtask
endmodule

// File: test/test_cmd_decoder.sv
/*
 self-checking bench for the memory map decoder against an integer model.
 assumes the core model launches requests on falling edges.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module test_cmd_decoder;
    import cmd_pkg::*;
    logic [15:0] fetch_addr, const_addr, exec_pc;
    logic [7:0]  data_addr, indirect_ptr, sfr_wdata;
    logic        clk, rst, fetch_req, const_req, const_scratch, indirect_sel, sfr_we, sfr_re;
    cmd_mode_e   data_mode;
    cmd_stk_e    stack_op;
    logic [16:0] fetch_flash_addr, const_flash_addr;
    logic [7:0]  ram_addr, sfr_addr, sfr_page, ptr_reg_addr, sfr_rdata, stack_pointer, push_addr;
    logic [2:0]  bit_pos;
    logic        ram_sel, ram_bit_sel, sfr_sel, sfr_bit_ok, sfr_rvalid, rec_overflow;
    logic        rec_underflow;
    int          err_count, comparisons, cyc, cb, fb, a, p, n_ovf, n_unf;
    int          pages[$] = '{0, 1, 2, 3, 15};
    cmd_core_model core (.clk, .fetch_addr, .fetch_req, .const_addr, .const_req,
        .const_scratch, .exec_pc, .data_mode, .data_addr, .indirect_ptr, .indirect_sel,
        .sfr_we, .sfr_re, .sfr_wdata, .stack_op);
    cmd_decoder dut (.clk, .rst, .fetch_addr, .fetch_req, .const_addr, .const_req,
        .const_scratch, .exec_pc, .data_mode, .data_addr, .indirect_ptr, .indirect_sel,
        .sfr_we, .sfr_re, .sfr_wdata, .stack_op, .fetch_flash_addr, .const_flash_addr,
        .ram_addr, .ram_sel, .ram_bit_sel, .bit_pos, .sfr_addr, .sfr_page, .sfr_sel,
        .sfr_bit_ok, .ptr_reg_addr, .sfr_rdata, .sfr_rvalid, .stack_pointer, .push_addr,
        .rec_overflow, .rec_underflow);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic final_report();
        if (err_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            final_report();
        end
    end
    always @(negedge clk) begin
        n_ovf <= n_ovf + int'(rec_overflow === 1'b1);
        n_unf <= n_unf + int'(rec_underflow === 1'b1);
    end
    task automatic acc(input cmd_mode_e m, input logic [7:0] ad, input logic [7:0] pt,
                       input logic s);
        core.md_nxt = m;
        core.da_nxt = ad;
        core.ip_nxt = pt;
        core.is_nxt = s;
        core.issue();
        core.issue();
    endtask
    task automatic chk_bank();
        core.sfr_rd(CMD_PBS_ADDR);
        core.issue();
        `CHK("bank rvalid", 1'b1, sfr_rvalid)
        `CHK("bank read", 8'((cb << 4) | fb), sfr_rdata)
        core.fr_nxt = 1'b1;
        core.fa_nxt = 16'h9abc;
        core.cr_nxt = 1'b1;
        core.ca_nxt = 16'hc123;
        core.issue();
        core.fr_nxt = 1'b1;
        core.fa_nxt = 16'h1234;
        core.cr_nxt = 1'b1;
        core.ca_nxt = 16'h5678;
        core.issue();
        `CHK("fetch hi", 17'((fb << 15) | 16'h1abc), fetch_flash_addr)
        `CHK("const hi", 17'((cb << 15) | 16'h4123), const_flash_addr)
        core.cr_nxt = 1'b1;
        core.cs_nxt = 1'b1;
        core.ca_nxt = 16'hf00d;
        core.issue();
        `CHK("fetch lo", 17'h01234, fetch_flash_addr)
        `CHK("const lo", 17'h05678, const_flash_addr)
        core.issue();
        `CHK("const scratch", 17'h0700d, const_flash_addr)
    endtask
    task automatic stk(input cmd_stk_e op, input int n);
        repeat (n) begin
            core.op_nxt = op;
            core.issue();
        end
    endtask
    initial begin
        void'($urandom(32'hd89bfee6));
        rst = 1'b1;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        `CHK("sp reset", 8'h07, stack_pointer)
        `CHK("push addr reset", 8'h08, push_addr)
        core.sfr_rd(CMD_SP_ADDR);
        core.issue();
        `CHK("sp read", 8'h07, sfr_rdata)
        cb = 1;
        fb = 1;
        chk_bank();
        for (int b = 0; b < 4; b++) begin
            a = $urandom;
            core.sfr_wr(CMD_PBS_ADDR, 8'((a & 8'hcc) | (b << 4) | (3 - b)), 16'h0100);
            cb = b;
            fb = 3 - b;
            chk_bank();
        end
        core.sfr_wr(CMD_PBS_ADDR, 8'h22, 16'h8400);
        cb = 2;
        chk_bank();
        core.sfr_wr(CMD_PAGE_ADDR, 8'h03, 16'h0000);
        core.sfr_wr(CMD_PBS_ADDR, 8'h31, 16'h0000);
        cb = 3;
        fb = 1;
        chk_bank();
        for (int i = 0; i < 10; i++) begin
            a = 8'h80 | ($urandom & ((i < 5) ? 8'h78 : 8'h7f));
            core.paged(8'(pages[i % 5]), 8'(a));
            core.issue();
            `CHK("sfr sel", 1'b1, sfr_sel)
            `CHK("sfr page", 8'(pages[i % 5]), sfr_page)
            `CHK("sfr addr", 8'(a), sfr_addr)
            `CHK("sfr byte only", 1'b0, sfr_bit_ok)
            `CHK("ram off", 1'b0, ram_sel)
        end
        core.sfr_wr(CMD_PAGE_ADDR, 8'h00, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            p = $urandom & 3;
            a = $urandom;
            core.sfr_wr(CMD_PSW_ADDR, 8'(p << CMD_RS_LSB), 16'h0000);
            acc(CMD_INDIRECT, 8'(a), 8'(a), i[0]);
            `CHK("ind ram", 1'b1, ram_sel)
            `CHK("ind addr", 8'(a), ram_addr)
            `CHK("ind sfr", 1'b0, sfr_sel)
            `CHK("ptr reg", 8'(p * 8 + i % 2), ptr_reg_addr)
            acc(CMD_DIRECT, 8'(a & 8'h7f), 8'h00, 1'b0);
            `CHK("dir ram", 1'b1, ram_sel)
            `CHK("dir addr", 8'(a & 8'h7f), ram_addr)
            `CHK("dir no bit", 1'b0, ram_bit_sel)
            acc(CMD_BIT, 8'(a & 8'h7f), 8'h00, 1'b0);
            `CHK("bit sel", 1'b1, ram_bit_sel)
            `CHK("bit byte", 8'(8'h20 + ((a & 8'h7f) >> 3)), ram_addr)
            `CHK("bit pos", 3'(a), bit_pos)
            acc(CMD_BIT, 8'(a | 8'h80), 8'h00, 1'b0);
            `CHK("sfr bit sel", 1'b1, sfr_sel)
            `CHK("sfr bit addr", 8'((a | 8'h80) & 8'hf8), sfr_addr)
            `CHK("sfr bit ok", 1'b1, sfr_bit_ok)
        end
        stk(CMD_SP_POP, 1);
        stk(CMD_SP_PUSH, 2);
        stk(CMD_SP_HOLD, 3);
        `CHK("sp push", 8'h08, stack_pointer)
        `CHK("push addr", 8'h09, push_addr)
        stk(CMD_SP_CALL, 15);
        stk(CMD_SP_PUSH, 1);
        stk(CMD_SP_RET, 16);
        stk(CMD_SP_POP, 1);
        stk(CMD_SP_HOLD, 4);
        `CHK("ovf count", 1, n_ovf)
        `CHK("unf count", 2, n_unf)
        final_report();
    end
endmodule
